// ### hw/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// ==========================================================================
// opcodes handled by this block
`define FSP_OP_RDSPR        8'h3C
`define FSP_OP_RDSR         8'h05
`define FSP_OP_WRSR         8'h01

// ==========================================================================
// answer bytes of the sector protection read
`define FSP_SPR_SET_BYTE    8'hFF
`define FSP_SPR_CLR_BYTE    8'h00

// ==========================================================================
// device_status field positions
`define FSP_ST_LOCK         7
`define FSP_ST_SEQ          6
`define FSP_ST_EPE          5
`define FSP_ST_WPP          4
`define FSP_ST_SUM_HI       3
`define FSP_ST_SUM_LO       2
`define FSP_ST_WEL          1
`define FSP_ST_BUSY         0

// ==========================================================================
// protection summary codes
`define FSP_SUM_NONE        2'b00
`define FSP_SUM_SOME        2'b01
`define FSP_SUM_ALL         2'b11

// ==========================================================================
// sector layout and reset values
`define FSP_NUM_SECTORS     19
`define FSP_BIG_SECTORS     4'hF
`define FSP_LOCK_RESET      1'b0
`define FSP_PROT_RESET      {`FSP_NUM_SECTORS{1'b1}}

// ==========================================================================
// frame positions, counted in bytes after chip select falls
`define FSP_ADDR_BYTES      3'h4
`define FSP_DATA_BYTE       3'h1
`define FSP_BYTE_CNT_MAX    3'h7

`endif

// ### hw/fsp_pkg.sv
package fsp_pkg;

   // =======================================================================
   // system clock domain state
   typedef struct packed {
      logic        csMeta;
      logic        csSync;
      logic        csPrev;
      logic        wpMeta;
      logic        wpSync;
      logic        lock;
      logic [18:0] prot;
      logic        hwLocked;
      logic        weClear;
   } fsp_sys_s;

   // =======================================================================
   // link clock state, cleared while chip select is high
   typedef struct packed {
      logic [2:0]  bitCnt;
      logic [2:0]  byteCnt;
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [7:0]  statMeta;
      logic [7:0]  statSync;
      logic [18:0] protMeta;
      logic [18:0] protSync;
   } fsp_link_s;

   // =======================================================================
   // link clock state that must survive the end of a frame
   typedef struct packed {
      logic        wsrSeen;
      logic        wsrDone;
      logic        wsrBit;
   } fsp_hold_s;

   // =======================================================================
   // falling edge output state
   typedef struct packed {
      logic        soBit;
      logic [7:0]  statLatch;
   } fsp_out_s;

   // =======================================================================
   // status inputs from the rest of the device
   typedef struct packed {
      logic        seqMode;
      logic        epeError;
      logic        write_enable_latch;
      logic        busy;
   } fsp_core_s;

endpackage

// ### hw/fsp_protect_status.sv
`include "fsp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module fsp_protect_status #(
   parameter int NUM_SECTORS = `FSP_NUM_SECTORS
) (
   // system clock and reset
   input  wire  logic                   clock,
   input  wire  logic                   nrst,
   // serial link pins
   input  wire  logic                   sck,
   input  wire  logic                   csN,
   input  wire  logic                   si,
   output logic                         so,
   output logic                         soEn,
   // protect pin, active low
   input  wire  logic                   wpN,
   // state from the rest of the device
   input  wire  fsp_pkg::fsp_core_s     core,
   // protect and unprotect requests from the command engine
   input  wire  logic                   secWriteReq,
   input  wire  logic                   secWriteVal,
   input  wire  logic [23:0]            secWriteAddr,
   // results towards the rest of the device
   output logic                         lockBit,
   output logic                         hwLocked,
   output logic [NUM_SECTORS-1:0]       protBits,
   output logic                         weClear
);

   // =======================================================================
   // helpers
   // sector decode
   function automatic logic [4:0] sectorIndex(input logic [23:0] a);
      logic [4:0] idx;
      idx = 5'h12;
      if (a[19:16] != `FSP_BIG_SECTORS) begin
         idx = {1'b0, a[19:16]};
      end else if (a[15:14] == 2'b00) begin
         idx = 5'h0F;
      end else if (a[15:14] == 2'b01) begin
         idx = a[13] ? 5'h11 : 5'h10;
      end
      return idx;
   endfunction

   function automatic logic [1:0] summary(input logic [18:0] p);
      logic [1:0] s;
      s = `FSP_SUM_SOME;
      if (&p) begin
         s = `FSP_SUM_ALL;
      end else if (!(|p)) begin
         s = `FSP_SUM_NONE;
      end
      return s;
   endfunction

   // =======================================================================
   // state
   fsp_pkg::fsp_sys_s  sys, next_sys;
   fsp_pkg::fsp_link_s lnk, next_lnk;
   fsp_pkg::fsp_hold_s hld, next_hld;
   fsp_pkg::fsp_out_s  sout, next_sout;
   logic [7:0]         status;
   logic               frameEnd;
   logic               wpAsserted;
   logic               rdsrActive;
   logic               rdsprActive;

   // status assembly; pin mirror is the synced pin and summary is decoded, other read-only fields are plain inputs
   always_comb begin
      status                                  = 8'h00;
      status[`FSP_ST_LOCK]                    = sys.lock;
      status[`FSP_ST_SEQ]                     = core.seqMode;
      status[`FSP_ST_EPE]                     = core.epeError;
      status[`FSP_ST_WPP]                     = sys.wpSync;
      status[`FSP_ST_SUM_HI:`FSP_ST_SUM_LO]   = summary(sys.prot);
      status[`FSP_ST_WEL]                     = core.write_enable_latch;
      status[`FSP_ST_BUSY]                    = core.busy;
   end

   assign wpAsserted = !sys.wpSync;
   assign frameEnd   = sys.csSync && !sys.csPrev;

   // =======================================================================
   // system domain: lock bit and sector bits
   // captured status write data is stable once chip select is high,
   // because the host stops the link clock; the synced edge qualifies it
   always_comb begin
      next_sys          = sys;
      next_sys.csMeta   = csN;
      next_sys.csSync   = sys.csMeta;
      next_sys.csPrev   = sys.csSync;
      next_sys.wpMeta   = wpN;
      next_sys.wpSync   = sys.wpMeta;
      next_sys.weClear  = 1'b0;
      next_sys.hwLocked = wpAsserted && sys.lock;
      // sector writes refused while locked; pin not involved here
      if (secWriteReq && !sys.lock) begin
         next_sys.prot[sectorIndex(secWriteAddr)] = secWriteVal;
      end
      if (frameEnd && hld.wsrSeen) begin
         next_sys.weClear = 1'b1;
         // commit needs a whole data byte and write enable
         if (hld.wsrDone && core.write_enable_latch) begin
            // pin low keeps a set bit; setting allowed; clear
            next_sys.lock = wpAsserted ? (sys.lock | hld.wsrBit) : hld.wsrBit;
         end
      end
   end

   // sectors protected and lock clear at reset
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sys <= '{csMeta: 1'b1, csSync: 1'b1, csPrev: 1'b1, wpMeta: 1'b1,
                  wpSync: 1'b1, lock: `FSP_LOCK_RESET, prot: `FSP_PROT_RESET,
                  hwLocked: 1'b0, weClear: 1'b0};
      end else begin
         sys <= next_sys;
      end
   end

   // =======================================================================
   // link domain, rising edge: shift in opcode, address and data
   always_comb begin
      next_lnk          = lnk;
      next_lnk.statMeta = status;
      next_lnk.statSync = lnk.statMeta;
      next_lnk.protMeta = sys.prot;
      next_lnk.protSync = lnk.protMeta;
      next_lnk.bitCnt   = lnk.bitCnt + 3'h1;
      // opcode first, then up to three address bytes
      if (lnk.byteCnt == 3'h0) begin
         next_lnk.opcode = {lnk.opcode[6:0], si};
      end else if (lnk.byteCnt < `FSP_ADDR_BYTES) begin
         next_lnk.addr = {lnk.addr[22:0], si};
      end
      if (lnk.bitCnt == 3'h7 && lnk.byteCnt != `FSP_BYTE_CNT_MAX) begin
         next_lnk.byteCnt = lnk.byteCnt + 3'h1;
      end
   end

   // status write capture, kept past chip select release
   always_comb begin
      next_hld = hld;
      if (lnk.byteCnt == 3'h0 && lnk.bitCnt == 3'h0) begin
         next_hld = '0;
      end
      if (lnk.byteCnt == 3'h0 && lnk.bitCnt == 3'h7) begin
         next_hld.wsrSeen = ({lnk.opcode[6:0], si} == `FSP_OP_WRSR);
      end
      if (lnk.opcode == `FSP_OP_WRSR && lnk.byteCnt == `FSP_DATA_BYTE) begin
         // only the top data bit is kept
         if (lnk.bitCnt == 3'h0) begin
            next_hld.wsrBit = si;
         end
         if (lnk.bitCnt == 3'h7) begin
            next_hld.wsrDone = 1'b1;
         end
      end
   end

   // frame state cleared whenever chip select is high
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         lnk <= '0;
      end else begin
         lnk <= next_lnk;
      end
   end

   // holding flops are cleared by the first edge of each frame instead
   always_ff @(posedge sck) begin
      hld <= next_hld;
   end

   // =======================================================================
   // link domain, falling edge: drive the serial output
   assign rdsrActive  = (lnk.opcode == `FSP_OP_RDSR) && (lnk.byteCnt != 3'h0);
   assign rdsprActive = (lnk.opcode == `FSP_OP_RDSPR) && (lnk.byteCnt >= `FSP_ADDR_BYTES);

   always_comb begin
      next_sout = sout;
      // the latched byte keeps one status sample steady while it shifts,
      // so a flag that moves mid byte cannot tear the byte in two
      if (rdsrActive) begin
         // no busy gating; fresh byte latched at each byte start
         if (lnk.bitCnt == 3'h0) begin
            next_sout.statLatch = lnk.statSync;
            next_sout.soBit     = lnk.statSync[7];
         end else begin
            next_sout.soBit = sout.statLatch[3'h7 - lnk.bitCnt];
         end
      end else if (rdsprActive) begin
         // every bit equals the stored bit; pin not involved
         next_sout.soBit = lnk.protSync[sectorIndex(lnk.addr)];
      end
   end

   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         sout <= '0;
      end else begin
         sout <= next_sout;
      end
   end

   // output enabled after the opcode for status reads, after the address for sector reads; off when deselected
   assign soEn     = !csN && (rdsrActive || rdsprActive);
   assign so       = sout.soBit;
   assign lockBit  = sys.lock;
   assign hwLocked = sys.hwLocked;
   assign protBits = sys.prot;
   assign weClear  = sys.weClear;

   // =======================================================================
   // checks
   // sectors all protected right after reset
   AST_PROT_RESET: assert property (@(posedge clock)
      $rose(nrst) |-> &sys.prot) else $error("sector bits not set after reset");
   AST_LOCK_RESET: assert property (@(posedge clock)
      !nrst |=> !sys.lock) else $error("lock bit not cleared by reset");
   AST_HW_LOCK: assert property (@(posedge clock) disable iff (!nrst)
      hwLocked == $past(!sys.wpSync && sys.lock)) else $error("hardware lock wrong");
   AST_SEC_IGNORED: assert property (@(posedge clock) disable iff (!nrst)
      sys.lock |=> $stable(sys.prot)) else $error("sector bits changed while locked");
   AST_LOCK_HELD: assert property (@(posedge clock) disable iff (!nrst)
      (sys.lock && !sys.wpSync) |=> sys.lock) else $error("lock cleared with pin low");
   AST_LOCK_SET: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen && hld.wsrDone && core.write_enable_latch && hld.wsrBit)
      |=> sys.lock) else $error("lock set refused");
   AST_LOCK_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen && hld.wsrDone && core.write_enable_latch && !hld.wsrBit && sys.wpSync)
      |=> !sys.lock) else $error("lock clear refused with pin high");
   AST_LOCK_NEEDS_WRITE: assert property (@(posedge clock) disable iff (!nrst)
      !(frameEnd && hld.wsrSeen && hld.wsrDone && core.write_enable_latch) |=> $stable(sys.lock))
      else $error("lock changed without a status write");
   AST_WE_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen) |=> weClear ##1 !weClear)
      else $error("write enable clear pulse wrong");
   AST_SUMMARY: assert property (@(posedge clock) disable iff (!nrst)
      (&sys.prot |-> status[3:2] == 2'b11) and (~|sys.prot |-> status[3:2] == 2'b00))
      else $error("protection summary wrong");
   AST_WPP: assert property (@(posedge clock) disable iff (!nrst)
      $rose(sys.wpMeta) |=> status[4]) else $error("pin mirror wrong");
   AST_SO_OFF: assert property (@(posedge clock)
      csN |-> !soEn) else $error("output driven while deselected");
   // an unlocked sector write lands in the addressed bit
   AST_SEC_WRITE: assert property (@(posedge clock) disable iff (!nrst)
      (secWriteReq && !sys.lock) |=>
      sys.prot[sectorIndex($past(secWriteAddr))] == $past(secWriteVal))
      else $error("sector write lost");
   // the clear pulse only follows a whole write opcode
   AST_WE_SOURCE: assert property (@(posedge clock) disable iff (!nrst)
      weClear |-> $past(frameEnd && hld.wsrSeen))
      else $error("write enable clear without a status write");
   // a mixed set of sector bits reads as some protected
   AST_SUM_SOME: assert property (@(posedge clock) disable iff (!nrst)
      (|sys.prot && !(&sys.prot)) |-> status[3:2] == 2'b01)
      else $error("mixed summary wrong");
   // a status write under hardware lock leaves the lock set
   AST_HW_REFUSE: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen && wpAsserted && sys.lock) |=> sys.lock)
      else $error("status write accepted under hardware lock");
   // no write enable, no change
   AST_LOCK_WEL: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen && !core.write_enable_latch) |=> $stable(sys.lock))
      else $error("lock changed without write enable");
   // a cut data byte aborts the write
   AST_LOCK_SHORT: assert property (@(posedge clock) disable iff (!nrst)
      (frameEnd && hld.wsrSeen && !hld.wsrDone) |=> $stable(sys.lock))
      else $error("lock changed by a short frame");
   // the data line rests low while deselected
   AST_SO_LOW: assert property (@(posedge clock)
      csN |-> !so) else $error("output data not cleared while deselected");

   // =======================================================================
   // link side checks, sampled where the host samples
   AST_SO_QUIET: assert property (@(posedge sck) disable iff (csN)
      (lnk.byteCnt == 3'h0) |-> !soEn) else $error("output on during opcode");
   // every answer bit of a sector read equals the stored bit
   AST_SPR_BITS: assert property (@(posedge sck) disable iff (csN)
      rdsprActive |-> so == lnk.protSync[sectorIndex(lnk.addr)])
      else $error("sector answer bit wrong");
   // status bits leave msb first from the latched byte
   AST_STAT_ORDER: assert property (@(posedge sck) disable iff (csN)
      rdsrActive |-> so == sout.statLatch[3'h7 - lnk.bitCnt])
      else $error("status bit order wrong");
   // each byte start takes the newest synced status
   AST_STAT_FRESH: assert property (@(posedge sck) disable iff (csN)
      (rdsrActive && lnk.bitCnt == 3'h1) |-> sout.statLatch == lnk.statSync)
      else $error("status byte not refreshed");

endmodule

`default_nettype wire

// ### verif/fsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// serial host, mode 0; its clock stands low between frames
module fsp_host_model (
   // link pins towards the device
   output logic      sck,
   output logic      csN,
   output logic      si,
   input  wire logic so
);
   // pins at time zero: clock and data low, chip select low for 1 ns
   initial begin
      sck = 1'b0;
      csN = 1'b0;
      si  = 1'b0;
      // a clean rising edge clears the device's frame state before any frame
      #1 csN = 1'b1;
   end

   // frame shape
   // request bits go out msb first, then answer bits are taken on rising edges
   task automatic xfer(input logic [63:0] tx, input int nTx, input int nRx,
                       output logic [63:0] rx);
      rx  = '0;
      csN = 1'b0;
      #3;
      for (int i = 0; i < nTx + nRx; i++) begin
         // past the request the data line toggles, so no stale value looks valid
         si = (i < nTx) ? tx[nTx-1-i] : ~si;
         #3 sck = 1'b1;
         if (i >= nTx)
            rx = {rx[62:0], so};
         #3 sck = 1'b0;
      end
      #3 csN = 1'b1;
      si = ~si;
   endtask
endmodule

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   typedef struct packed {
      logic [23:0] addr;
      logic [23:0] rdAddr;
      logic        val;
      logic        wp;
      logic [4:0]  idx;
   } fsp_tb_row_s;

   logic               clock, nrst, sck, csN, si, so, soEn, wpN;
   logic               secWriteReq, secWriteVal, lockBit, hwLocked, weClear;
   logic [23:0]        secWriteAddr;
   logic [18:0]        protBits, expProt;
   logic               expLock;
   logic [63:0]        rx;
   logic [7:0]         e1;
   fsp_pkg::fsp_core_s core;
   int                 errors, num_checks;
   // sector writes and reads, small sectors and ignored top bits among them
   fsp_tb_row_s        rows [7] = '{
      '{24'h00_0000, 24'h00_FFFF, 1'b0, 1'b1, 5'd0},
      '{24'h0E_8000, 24'h0E_0001, 1'b0, 1'b0, 5'd14},
      '{24'h0F_0000, 24'hFF_3FFF, 1'b0, 1'b1, 5'd15},
      '{24'h0F_4000, 24'h0F_5FFF, 1'b0, 1'b0, 5'd16},
      '{24'h0F_6000, 24'h0F_7ABC, 1'b0, 1'b1, 5'd17},
      '{24'h0F_8000, 24'h0F_FFFF, 1'b0, 1'b1, 5'd18},
      '{24'h0F_8000, 24'h0F_8123, 1'b1, 1'b0, 5'd18}};

   fsp_protect_status i_fsp_protect_status (.clock(clock), .nrst(nrst), .sck(sck),
      .csN(csN), .si(si), .so(so), .soEn(soEn), .wpN(wpN), .core(core),
      .secWriteReq(secWriteReq), .secWriteVal(secWriteVal), .secWriteAddr(secWriteAddr),
      .lockBit(lockBit), .hwLocked(hwLocked), .protBits(protBits), .weClear(weClear));
   fsp_host_model i_fsp_host_model (.sck(sck), .csN(csN), .si(si), .so(so));

   // ========================================================================
   // clock and helpers
   always #5 clock = ~clock;

   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [7:0] expStat();
      logic [1:0] sum;
      sum = (&expProt) ? 2'b11 : ((|expProt) ? 2'b01 : 2'b00);
      return {expLock, core[3], core[2], wpN, sum, core[1], core[0]};
   endfunction

   task automatic secWrite(input logic [23:0] a, input logic v);
      secWriteReq  = 1'b1;
      secWriteAddr = a;
      secWriteVal  = v;
      cyc(1);
      secWriteReq  = 1'b0;
      cyc(1);
   endtask

   // a short read also shows the output floats wherever chip select rises
   task automatic rdStat(input int n);
      logic [7:0] e;
      cyc(6);
      e = expStat();
      i_fsp_host_model.xfer(64'h05, 8, n, rx);
      chk(rx, 64'(e >> (8 - n)), "status");
      #1;
      chk({soEn, so}, 2'b00, "float");
      cyc(1);
   endtask

   // the clear pulse bounds the wait; lock is compared in that same cycle
   task automatic wsr(input logic [7:0] d, input int n);
      int k;
      i_fsp_host_model.xfer({48'h0, 8'h01, d} >> (16 - n), n, 0, rx);
      for (k = 0; k < 20 && weClear !== 1'b1; k++)
         cyc(1);
      chk(weClear, 1'b1, "clear pulse");
      chk(lockBit, expLock, "lock");
      if (weClear !== 1'b1)
         wrap_up();
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ========================================================================
   // main sequence
   initial begin
      clock = 1'b0; nrst = 1'b0; wpN = 1'b1; core = '0; secWriteReq = 1'b0;
      secWriteVal = 1'b0; secWriteAddr = '0; expLock = 1'b0; expProt = '1;
      errors = 0; num_checks = 0;
      cyc(12);
      nrst = 1'b1;
      cyc(3);
      chk(protBits, expProt, "reset sectors");
      rdStat(8);
      $display("test reset finished");
      foreach (rows[r]) begin
         wpN = rows[r].wp;
         secWrite(rows[r].addr, rows[r].val);
         expProt[rows[r].idx] = rows[r].val;
         chk(protBits, expProt, "sectors");
         i_fsp_host_model.xfer({32'h0, 8'h3C, rows[r].rdAddr}, 32, 16, rx);
         chk(rx[15:0], {16{rows[r].val}}, "sector read");
         cyc(1);
      end
      rdStat(8);
      for (int i = 0; i < 15; i++)
         secWrite({4'h0, 4'(i), 16'h0000}, 1'b0);
      secWrite(24'h0F_8000, 1'b0);
      expProt = '0;
      rdStat(8);
      $display("test sectors finished");
      // lock set with the pin low gives a hardware lock
      core = 4'b0010;
      wpN = 1'b0;
      expLock = 1'b1;
      wsr(8'h80, 16);
      cyc(4);
      chk(hwLocked, 1'b1, "hw lock");
      rdStat(8);
      secWrite(24'h00_0000, 1'b1);
      chk(protBits, expProt, "locked sectors");
      wsr(8'h00, 16);
      wpN = 1'b1;
      cyc(4);
      chk(hwLocked, 1'b0, "sw lock");
      secWrite(24'h0F_4000, 1'b1);
      chk(protBits, expProt, "sw locked sectors");
      expLock = 1'b0;
      wsr(8'h7F, 16);
      core = 4'b1110;
      rdStat(5);
      wsr(8'h80, 12);
      core = 4'b0000;
      wsr(8'h80, 16);
      $display("test lock finished");
      // busy drops mid poll; the third byte must show it
      core = 4'b0001;
      cyc(6);
      e1 = expStat();
      fork
         i_fsp_host_model.xfer(64'h05, 8, 24, rx);
         begin
            cyc(6);
            core[0] = 1'b0;
         end
      join
      chk(rx[23:16], e1, "busy poll");
      chk(rx[7:0], expStat(), "fresh poll");
      cyc(1);
      $display("test poll finished");
      // reset in mid-run after locking
      core = 4'b0010;
      expLock = 1'b1;
      wsr(8'h80, 16);
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(3);
      expLock = 1'b0;
      expProt = '1;
      chk({lockBit, protBits}, {expLock, expProt}, "second reset");
      i_fsp_host_model.xfer({32'h0, 8'h3C, 24'h0F_6000}, 32, 3, rx);
      chk(rx[2:0], 3'b111, "short sector read");
      #1;
      chk({soEn, so}, 2'b00, "sector float");
      $display("test second reset finished");
      wrap_up();
   end
endmodule

`default_nettype wire
